/* File: src/pmc_pkg.sv */
package pmc_pkg;
  localparam logic [3:0] PMC_ADDR_OPCR = 4'h0;
  localparam logic [3:0] PMC_ADDR_SOPCR = 4'h1;
  localparam logic [3:0] PMC_ADDR_LPCFG = 4'h2;
  localparam logic [3:0] PMC_ADDR_STATUS = 4'h3;
  localparam logic [3:0] PMC_ADDR_CLKREQ = 4'h4;
  localparam logic [2:0] PMC_POWER_MODE_SELECT_FIELD_HIGH = 3'h0;
  localparam logic [2:0] PMC_POWER_MODE_SELECT_FIELD_MID = 3'h2;
  localparam int PMC_POWER_MODE_SELECT_FIELD_LSB = 0;
  localparam int PMC_SUB_POWER_MODE_BIT_BIT = 0;
  localparam logic [2:0] PMC_POWER_MODE_SELECT_FIELD_RESET = 3'h0;
  localparam logic PMC_SUB_POWER_MODE_BIT_RESET = 1'b0;
  localparam int PMC_MAX_HIGH_KHZ = 32000;
  localparam int PMC_MAX_MID_KHZ = 12000;
  localparam int PMC_MAX_LOW_HZ = 32768;
  localparam int PMC_PLL_MIN_MV = 2400;
  localparam logic [3:0] PMC_SLEEP_RESET = 4'h0;

  typedef enum logic [1:0] {
    PMC_SPD_HIGH = 2'b00,
    PMC_SPD_MID = 2'b01,
    PMC_SPD_LOW = 2'b10,
    PMC_SPD_BAD = 2'b11
  } pmc_speed_t;

  typedef enum logic [1:0] {
    PMC_LP_SLEEP = 2'b00,
    PMC_LP_DEEP = 2'b01,
    PMC_LP_STBY = 2'b10
  } pmc_lpsel_t;

  typedef enum logic [1:0] {
    PMC_ST_RUN = 2'b00,
    PMC_ST_SLEEP = 2'b01,
    PMC_ST_DEEP = 2'b10,
    PMC_ST_STBY = 2'b11
  } pmc_state_t;

  // oscillator enables: pll, fast int, slow int, main, sub, watchdog
  typedef struct packed {
    logic pll;
    logic fast_int;
    logic slow_int;
    logic main;
    logic sub;
    logic wdt;
  } pmc_osc_t;

  // domain gates: cpu, low ram, transfer ctrl, flash, periph, io hold, always-on
  typedef struct packed {
    logic cpu_run;
    logic low_ram_run;
    logic dtc_run;
    logic flash_run;
    logic periph_run;
    logic io_hold;
    logic aon_run;
  } pmc_dom_t;
endpackage : pmc_pkg

/* File: src/pmc_clk_limit.sv */
// checks requested clock against the ceiling of the current speed mode
module pmc_clk_limit
  import pmc_pkg::*;
(
  input wire logic [31:0] i_freq_hz, // requested clock in Hz
  input wire pmc_speed_t i_speed, // decoded mode
  output logic o_ok // request within ceiling
);
  always_comb begin
    unique case (i_speed)
      PMC_SPD_HIGH: o_ok = (i_freq_hz <= 32'(PMC_MAX_HIGH_KHZ * 1000));
      PMC_SPD_MID: o_ok = (i_freq_hz <= 32'(PMC_MAX_MID_KHZ * 1000));
      PMC_SPD_LOW: o_ok = (i_freq_hz <= 32'(PMC_MAX_LOW_HZ));
      default: o_ok = 1'b0;
    endcase
  end
endmodule : pmc_clk_limit

/* File: src/pmc_top.sv */
module pmc_top
  import pmc_pkg::*;
(
  input wire logic I_CLOCK, // 10 MHz system clock
  input wire logic I_RST_N, // synchronous reset, active low
  input wire logic [3:0] I_ADDR, // register index
  input wire logic [7:0] I_WDATA, // write data
  input wire logic I_WR, // write strobe
  input wire logic I_RD, // read strobe
  input wire logic I_WAIT, // processor executes the wait instruction
  input wire logic I_IRQ, // any interrupt request
  input wire logic I_VCC_ABOVE_2V4, // supply above pll threshold
  output logic [7:0] O_RDATA, // read data, cycle after read strobe
  output pmc_osc_t O_OSC_EN, // oscillator enables
  output pmc_dom_t O_DOM, // domain run and hold controls
  output pmc_speed_t O_SPEED, // current speed mode
  output logic O_CLK_VIOLATION, // requested clock above ceiling
  output logic O_WAKE // one-cycle pulse: resume with interrupt handling
);
  logic [2:0] power_mode_select_field, next_power_mode_select_field;
  logic sub_power_mode_bit, next_sub_power_mode_bit;
  pmc_lpsel_t lpsel, next_lpsel;
  logic [3:0] osc_req, next_osc_req; // pll, fast, slow, main requested
  logic [31:0] freq_hz, next_freq_hz;
  logic [7:0] clkreq, next_clkreq; // clock request byte as written
  pmc_state_t state, next_state;
  logic [7:0] rdata, next_rdata;
  pmc_osc_t osc, next_osc;
  pmc_dom_t dom, next_dom;
  pmc_speed_t speed, next_speed;
  logic viol, next_viol;
  logic wake, next_wake;
  logic clk_ok;

  function automatic pmc_speed_t decode_speed(input logic [2:0] f, input logic s);
    if (s) begin
      return PMC_SPD_LOW;
    end
    if (f == PMC_POWER_MODE_SELECT_FIELD_HIGH) begin
      return PMC_SPD_HIGH;
    end
    if (f == PMC_POWER_MODE_SELECT_FIELD_MID) begin
      return PMC_SPD_MID;
    end
    return PMC_SPD_BAD;
  endfunction : decode_speed

  // memories and the transfer unit run only while awake or in light sleep
  function automatic logic mem_awake(input pmc_state_t st);
    return (st == PMC_ST_RUN) || (st == PMC_ST_SLEEP);
  endfunction : mem_awake

  function automatic pmc_dom_t decode_domains(input pmc_state_t st);
    pmc_dom_t d;
    d.cpu_run = (st == PMC_ST_RUN);
    d.low_ram_run = mem_awake(st);
    d.dtc_run = mem_awake(st);
    d.flash_run = mem_awake(st);
    d.periph_run = (st != PMC_ST_STBY);
    d.io_hold = (st == PMC_ST_STBY);
    d.aon_run = 1'b1;
    return d;
  endfunction : decode_domains

  pmc_clk_limit u_limit (
    .i_freq_hz(freq_hz),
    .i_speed(speed),
    .o_ok(clk_ok)
  );

  // register file
  always_comb begin
    next_power_mode_select_field = power_mode_select_field;
    next_sub_power_mode_bit = sub_power_mode_bit;
    next_lpsel = lpsel;
    next_osc_req = osc_req;
    next_freq_hz = freq_hz;
    next_clkreq = clkreq;
    // read data stands for one cycle only and is zero otherwise
    next_rdata = 8'h00;
    if (I_WR) begin
      unique case (I_ADDR)
        PMC_ADDR_OPCR: next_power_mode_select_field = I_WDATA[PMC_POWER_MODE_SELECT_FIELD_LSB +: 3];
        PMC_ADDR_SOPCR: next_sub_power_mode_bit = I_WDATA[PMC_SUB_POWER_MODE_BIT_BIT];
        PMC_ADDR_LPCFG: begin
          // code 3 aliases standby so the stored selection is always legal
          next_lpsel = (I_WDATA[1:0] == 2'b11) ? PMC_LP_STBY : pmc_lpsel_t'(I_WDATA[1:0]);
          next_osc_req = I_WDATA[7:4];
        end
        // clock request in Hz, written as one byte times 256 kHz, 0 means sub-clock
        PMC_ADDR_CLKREQ: begin
          next_freq_hz = (I_WDATA == 8'h00) ? 32'(PMC_MAX_LOW_HZ)
                                            : 32'(I_WDATA) * 32'h0003_E800;
          next_clkreq = I_WDATA;
        end
        default: ;
      endcase
    end
    if (I_RD) begin
      unique case (I_ADDR)
        PMC_ADDR_OPCR: next_rdata = {5'h00, power_mode_select_field};
        PMC_ADDR_SOPCR: next_rdata = {7'h00, sub_power_mode_bit};
        PMC_ADDR_LPCFG: next_rdata = {osc_req, 2'b00, lpsel};
        PMC_ADDR_STATUS: next_rdata = {2'b00, viol, state, speed, 1'b0};
        // readback gives the byte as written, not the derived frequency
        PMC_ADDR_CLKREQ: next_rdata = clkreq;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  // low power state machine and wake pulse
  always_comb begin
    next_state = state;
    next_wake = 1'b0;
    unique case (state)
      PMC_ST_RUN: begin
        // a pending interrupt does not block entry: it ends the state on the next edge
        if (I_WAIT) begin
          unique case (lpsel)
            PMC_LP_SLEEP: next_state = PMC_ST_SLEEP;
            PMC_LP_DEEP: next_state = PMC_ST_DEEP;
            default: next_state = PMC_ST_STBY;
          endcase
        end
      end
      PMC_ST_SLEEP, PMC_ST_DEEP, PMC_ST_STBY: begin
        // any interrupt ends the state; an interrupt while running is ignored
        if (I_IRQ) begin
          next_state = PMC_ST_RUN;
          next_wake = 1'b1;
        end
      end
    endcase
  end

  // output decode
  always_comb begin
    // decoded from the next values so a mode write shows at the edge that takes it
    next_speed = decode_speed(next_power_mode_select_field, next_sub_power_mode_bit);
    // speed check is advisory: software orders writes, hardware only flags a breach
    next_viol = !clk_ok;
    // sub-clock and watchdog oscillators are stopped by this block only while reset is held
    next_osc.sub = 1'b1;
    next_osc.wdt = 1'b1;
    // low speed leaves the sub-clock as the only usable source
    if (next_speed == PMC_SPD_LOW) begin
      next_osc.pll = 1'b0;
      next_osc.fast_int = 1'b0;
      next_osc.slow_int = 1'b0;
      next_osc.main = 1'b0;
    end else begin
      // pll also waits for a supply above its threshold
      next_osc.pll = next_osc_req[3] && I_VCC_ABOVE_2V4;
      next_osc.fast_int = next_osc_req[2];
      next_osc.slow_int = next_osc_req[1];
      next_osc.main = next_osc_req[0];
    end
    // standby overrides the speed gating whatever software requested
    if (next_state == PMC_ST_STBY) begin
      next_osc.pll = 1'b0;
      next_osc.fast_int = 1'b0;
      next_osc.slow_int = 1'b0;
      next_osc.main = 1'b0;
    end
    next_dom = decode_domains(next_state);
  end

  // register file
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      power_mode_select_field <= PMC_POWER_MODE_SELECT_FIELD_RESET;
      sub_power_mode_bit <= PMC_SUB_POWER_MODE_BIT_RESET;
      lpsel <= PMC_LP_SLEEP;
      osc_req <= PMC_SLEEP_RESET;
      freq_hz <= 32'(PMC_MAX_LOW_HZ);
      clkreq <= 8'h00;
      rdata <= 8'h00;
    end else begin
      power_mode_select_field <= next_power_mode_select_field;
      sub_power_mode_bit <= next_sub_power_mode_bit;
      lpsel <= next_lpsel;
      osc_req <= next_osc_req;
      freq_hz <= next_freq_hz;
      clkreq <= next_clkreq;
      rdata <= next_rdata;
    end
  end

  // low power state
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      state <= PMC_ST_RUN;
      wake <= 1'b0;
    end else begin
      state <= next_state;
      wake <= next_wake;
    end
  end

  // registered outputs
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_N) begin
      osc <= '0;
      dom <= '0;
      speed <= PMC_SPD_HIGH;
      viol <= 1'b0;
    end else begin
      osc <= next_osc;
      dom <= next_dom;
      speed <= next_speed;
      viol <= next_viol;
    end
  end

  assign O_RDATA = rdata;
  assign O_OSC_EN = osc;
  assign O_DOM = dom;
  assign O_SPEED = speed;
  assign O_CLK_VIOLATION = viol;
  assign O_WAKE = wake;
endmodule : pmc_top

/* File: tb/pmc_sva.sv */
module pmc_sva
  import pmc_pkg::*;
(
  input wire logic I_CLOCK, // clock
  input wire logic I_RST_N, // reset
  input wire logic [3:0] I_ADDR, // index
  input wire logic [7:0] I_WDATA, // data
  input wire logic I_WR, // write
  input wire logic I_RD, // read
  input wire logic I_WAIT, // wait
  input wire logic I_IRQ, // irq
  input wire logic I_VCC_ABOVE_2V4, // supply
  input wire logic [7:0] O_RDATA, // rdata
  input wire pmc_osc_t O_OSC_EN, // osc
  input wire pmc_dom_t O_DOM, // domains
  input wire pmc_speed_t O_SPEED, // speed
  input wire logic O_CLK_VIOLATION, // viol
  input wire logic O_WAKE // wake
);
  logic rdy;
  logic next_rdy;
  // outputs are all zero on the first edge after release, so wait one edge
  always_comb next_rdy = I_RST_N;
  always_ff @(posedge I_CLOCK) rdy <= next_rdy;
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (!I_RST_N);
  AST_WAKE_ONE: assert property (O_WAKE |=> !O_WAKE) else $error("wake too long");
  AST_WAKE_CAUSE: assert property (O_WAKE |-> O_DOM.cpu_run && $past(I_IRQ)
    && !$past(O_DOM.cpu_run)) else $error("wake without cause");
  AST_IRQ_RESUME: assert property (rdy && I_IRQ && !O_DOM.cpu_run |=> O_WAKE
    && O_DOM.cpu_run) else $error("no resume");
  AST_WAIT_HALT: assert property (rdy && I_WAIT && !I_IRQ && O_DOM.cpu_run
    |=> !O_DOM.cpu_run) else $error("wait ignored");
  AST_ONLY_WAIT: assert property (rdy && O_DOM.cpu_run && !I_WAIT
    |=> O_DOM.cpu_run) else $error("halt without wait");
  AST_STBY_OSC: assert property (rdy && !O_DOM.periph_run |-> O_OSC_EN[5:2] == 4'h0
    && O_OSC_EN.wdt && O_DOM.io_hold) else $error("standby clocks");
  AST_LOW_OSC: assert property (O_SPEED == PMC_SPD_LOW |-> O_OSC_EN[5:2] == 4'h0)
    else $error("low speed osc");
  AST_PLL_VCC: assert property (O_OSC_EN.pll |-> $past(I_VCC_ABOVE_2V4))
    else $error("pll on low supply");
  AST_DEEP_STOP: assert property (rdy && !O_DOM.low_ram_run |-> !O_DOM.dtc_run
    && !O_DOM.flash_run && !O_DOM.cpu_run) else $error("deep sleep domains");
  AST_AON: assert property (rdy |-> O_DOM.aon_run && O_OSC_EN.wdt)
    else $error("always-on stopped");
  AST_BAD_VIOL: assert property (O_SPEED == PMC_SPD_BAD |=> O_CLK_VIOLATION)
    else $error("illegal mode not flagged");
endmodule : pmc_sva
bind pmc_top pmc_sva pmc_sva_inst (
  .I_CLOCK(I_CLOCK), .I_RST_N(I_RST_N), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
  .I_WR(I_WR), .I_RD(I_RD), .I_WAIT(I_WAIT), .I_IRQ(I_IRQ),
  .I_VCC_ABOVE_2V4(I_VCC_ABOVE_2V4), .O_RDATA(O_RDATA), .O_OSC_EN(O_OSC_EN),
  .O_DOM(O_DOM), .O_SPEED(O_SPEED), .O_CLK_VIOLATION(O_CLK_VIOLATION), .O_WAKE(O_WAKE)
);

/* File: tb/pmc_top_tb.sv */
module pmc_top_tb
  import pmc_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic I_CLOCK = 0, I_RST_N = 0, I_WR = 0, I_RD = 0, I_WAIT = 0, I_IRQ = 0;
  logic I_VCC_ABOVE_2V4 = 1, O_CLK_VIOLATION, O_WAKE, s, vcc;
  logic [3:0] I_ADDR = 4'h0, o;
  logic [7:0] I_WDATA = 8'h00, O_RDATA, rv, v;
  logic [7:0] cv [8] = '{8'h7E, 8'h2F, 8'h00, 8'h01, 8'h7D, 8'h2E, 8'h00, 8'hFF};
  logic [2:0] f;
  pmc_osc_t O_OSC_EN;
  pmc_dom_t O_DOM;
  pmc_speed_t O_SPEED, sp, pv = PMC_SPD_HIGH;
  int err_total = 0, check_count = 0;
  integer seed = 32'h5A00;
  always #50 I_CLOCK = ~I_CLOCK;
  pmc_top pmc_top_inst (
    .I_CLOCK(I_CLOCK), .I_RST_N(I_RST_N), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
    .I_WR(I_WR), .I_RD(I_RD), .I_WAIT(I_WAIT), .I_IRQ(I_IRQ),
    .I_VCC_ABOVE_2V4(I_VCC_ABOVE_2V4), .O_RDATA(O_RDATA), .O_OSC_EN(O_OSC_EN),
    .O_DOM(O_DOM), .O_SPEED(O_SPEED), .O_CLK_VIOLATION(O_CLK_VIOLATION), .O_WAKE(O_WAKE)
  );
  task automatic chk(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge I_CLOCK);
    I_WR <= 1'b1;
    I_ADDR <= a;
    I_WDATA <= d;
    @(posedge I_CLOCK);
    I_WR <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge I_CLOCK);
    I_RD <= 1'b1;
    I_ADDR <= a;
    @(posedge I_CLOCK);
    I_RD <= 1'b0;
    @(negedge I_CLOCK);
    d = O_RDATA;
  endtask : rd
  // one-cycle pulse on the interrupt line (irq high) or the wait line
  task automatic pulse(input logic irq);
    @(posedge I_CLOCK);
    if (irq) begin
      I_IRQ <= 1'b1;
    end else begin
      I_WAIT <= 1'b1;
    end
    @(posedge I_CLOCK);
    I_IRQ <= 1'b0;
    I_WAIT <= 1'b0;
    @(negedge I_CLOCK);
  endtask : pulse
  function automatic pmc_speed_t exp_spd(input logic [2:0] fd, input logic sb);
    if (sb) return PMC_SPD_LOW;
    if (fd == PMC_POWER_MODE_SELECT_FIELD_HIGH) return PMC_SPD_HIGH;
    return (fd == PMC_POWER_MODE_SELECT_FIELD_MID) ? PMC_SPD_MID : PMC_SPD_BAD;
  endfunction : exp_spd
  // ceiling in Hz per mode; an illegal field allows no clock at all
  function automatic longint ceil_hz(input pmc_speed_t sd);
    if (sd == PMC_SPD_HIGH) return longint'(PMC_MAX_HIGH_KHZ) * 1000;
    if (sd == PMC_SPD_MID) return longint'(PMC_MAX_MID_KHZ) * 1000;
    return (sd == PMC_SPD_LOW) ? longint'(PMC_MAX_LOW_HZ) : 0;
  endfunction : ceil_hz
  function automatic logic exp_viol(input pmc_speed_t sd, input logic [7:0] rq);
    longint hz;
    hz = (rq == 8'h00) ? PMC_MAX_LOW_HZ : longint'(rq) * 256000;
    return hz > ceil_hz(sd);
  endfunction : exp_viol
  function automatic pmc_dom_t exp_dom(input int k);
    // sleep keeps memories, deep stops them, standby also stops periph and holds io
    return (k == 0) ? 7'h3D : (k == 1) ? 7'h05 : 7'h03;
  endfunction : exp_dom
  task automatic final_report;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report
  initial begin
    #2000000;
    err_total++;
    final_report;
  end
  initial begin
    repeat (3) @(posedge I_CLOCK);
    I_RST_N <= 1'b1;
    rd(PMC_ADDR_STATUS, rv);
    chk(rv === 8'h00, "status after reset");
    for (int i = 0; i < 24; i++) begin
      // first eight are ceiling boundaries, the rest random
      f = ((i < 8) ? i[0] : $random(seed) & 1) ? PMC_POWER_MODE_SELECT_FIELD_MID : PMC_POWER_MODE_SELECT_FIELD_HIGH;
      s = (i < 8) ? i[1] : 1'($random(seed));
      v = (i < 8) ? cv[i] : 8'($random(seed));
      o = 4'($random(seed));
      vcc = 1'($random(seed));
      sp = exp_spd(f, s);
      @(posedge I_CLOCK);
      I_VCC_ABOVE_2V4 <= vcc;
      // speeding up: mode bits first; slowing down: clock first
      if (ceil_hz(sp) >= ceil_hz(pv)) begin
        wr(PMC_ADDR_OPCR, {5'h00, f});
        wr(PMC_ADDR_SOPCR, {7'h00, s});
        wr(PMC_ADDR_LPCFG, {o, 4'h0});
        wr(PMC_ADDR_CLKREQ, v);
      end else begin
        wr(PMC_ADDR_CLKREQ, v);
        wr(PMC_ADDR_LPCFG, {o, 4'h0});
        wr(PMC_ADDR_OPCR, {5'h00, f});
        wr(PMC_ADDR_SOPCR, {7'h00, s});
      end
      pv = sp;
      repeat (3) @(negedge I_CLOCK);
      chk(O_SPEED === sp, "speed decode");
      chk(O_CLK_VIOLATION === exp_viol(sp, v), "clock ceiling");
      chk(O_OSC_EN[5:2] === ((sp == PMC_SPD_LOW) ? 4'h0 : o & {vcc, 3'h7}), "osc");
      chk(O_OSC_EN.sub === 1'b1, "sub clock");
      rd(PMC_ADDR_CLKREQ, rv);
      chk(rv === v, "clock request readback");
    end
    wr(PMC_ADDR_CLKREQ, 8'h00);
    wr(PMC_ADDR_SOPCR, 8'h00);
    repeat (2) @(negedge I_CLOCK);
    chk(O_CLK_VIOLATION === 1'b0, "slowest clock");
    for (int k = 0; k < 3; k++) begin
      wr(PMC_ADDR_LPCFG, {6'h3C, 2'(k)});
      pulse(1'b1);
      chk(O_WAKE === 1'b0 && O_DOM.cpu_run === 1'b1, "irq in run");
      pulse(1'b0);
      chk(O_DOM === exp_dom(k), "domains");
      chk(O_OSC_EN === ((k == 2) ? 6'h03 : {vcc, 5'h1F}), "lp osc");
      rd(PMC_ADDR_STATUS, rv);
      chk(rv[4:3] === 2'(k + 1), "state");
      pulse(1'b1);
      chk(O_WAKE === 1'b1 && O_DOM.cpu_run === 1'b1, "wake");
      @(negedge I_CLOCK);
      chk(O_WAKE === 1'b0, "wake pulse");
    end
    wr(PMC_ADDR_OPCR, 8'h02);
    wr(4'hF, 8'hA5);
    rd(4'hF, rv);
    chk(rv === 8'h00, "unmapped read");
    rd(PMC_ADDR_OPCR, rv);
    chk(rv === 8'h02, "mode field kept");
    wr(PMC_ADDR_OPCR, 8'h05);
    repeat (2) @(negedge I_CLOCK);
    chk(O_SPEED === exp_spd(3'h5, 1'b0), "illegal field");
    chk(O_CLK_VIOLATION === exp_viol(PMC_SPD_BAD, 8'h00), "illegal field flag");
    @(posedge I_CLOCK);
    I_RST_N <= 1'b0;
    repeat (2) @(posedge I_CLOCK);
    @(negedge I_CLOCK);
    chk(O_DOM === 7'h00 && O_WAKE === 1'b0 && O_SPEED === PMC_SPD_HIGH, "held in reset");
    @(posedge I_CLOCK);
    I_RST_N <= 1'b1;
    rd(PMC_ADDR_OPCR, rv);
    chk(rv === 8'h00 && O_SPEED === PMC_SPD_HIGH, "second reset");
    final_report;
  end
endmodule : pmc_top_tb
